// >>> inc/sac_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH
// ***************************************************************
// register byte addresses
// ***************************************************************
`define SAC_STATUS_ADDR 32'hFFFF050C
`define SAC_RESULT_ADDR 32'hFFFF0510
`define SAC_IFRST_ADDR  32'hFFFF0514
`define SAC_GAIN_ADDR   32'hFFFF0530
`define SAC_OFS_ADDR    32'hFFFF0534
`define SAC_CTRL_ADDR   32'hFFFF0538
`define SAC_IMASK_ADDR  32'hFFFF053C
`define SAC_ISTAT_ADDR  32'hFFFF0540
// ***************************************************************
// fields, reset values and conversion constants
// ***************************************************************
`define SAC_CTRL_START_BIT  0
`define SAC_CTRL_SINGLE_BIT 1
`define SAC_GAIN_RST   10'h000
`define SAC_OFS_RST    10'h000
`define SAC_IMASK_RST  1'h0
`define SAC_MSB_IDX    4'hB
`define SAC_CODE_MAX   12'hFFF
`define SAC_CONV_STEPS 4'hC
`endif

// >>> inc/sac_pkg.sv
// types shared by the converter control block
`default_nettype none
package sac_pkg;
  // one-hot sequencer states
  typedef enum logic [5:0] {
    SAC_ST_ACQ  = 6'h01,
    SAC_ST_OPEN = 6'h02,
    SAC_ST_MOVE = 6'h04,
    SAC_ST_CONV = 6'h08,
    SAC_ST_CORR = 6'h10
  } sac_state_t;

  // whole state of the block
  typedef struct packed {
    sac_state_t  state;
    logic [3:0]  bit_idx;
    logic [11:0] trial;
    logic [11:0] raw;
    logic [9:0]  gain;
    logic [9:0]  ofs;
    logic [11:0] result;
    logic        ready;
    logic        single;
    logic        istat;
    logic        imask;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bal_sw;
    logic        pos_sw;
    logic        neg_sw;
    logic        neg_gnd;
    logic        busy;
    logic        irq;
  } sac_regs_t;
endpackage
`default_nettype wire

// >>> design/sac_ctrl.sv
// successive-approximation converter sequencer, trim and register file
`include "sac_map.svh"
`default_nettype none
module sac_ctrl
  import sac_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // analog front end
  input  wire logic        comp_in,
  output logic      [11:0] cap_dac_out,
  output logic             comparator_balance_switch_out,
  output logic             positive_input_switch_out,
  output logic             negative_input_switch_out,
  output logic             negative_ground_tie_out,
  output logic             busy_out,
  // interrupt
  output logic             irq_out
);

  // ***************************************************************
  // defaults
  // ***************************************************************

  // reset image, shared by the async reset and the interface reset
  function automatic sac_regs_t reg_defaults();
    sac_regs_t d;
    d         = '0;
    d.state   = SAC_ST_ACQ;
    d.gain    = `SAC_GAIN_RST;
    d.ofs     = `SAC_OFS_RST;
    d.imask   = `SAC_IMASK_RST;
    d.bal_sw  = 1'b1;
    return d;
  endfunction

  sac_regs_t st_r;
  sac_regs_t st_nxt;

  logic               acc;
  logic               start;
  logic               done;
  logic signed [22:0] prod;
  logic signed [24:0] quarter;
  logic        [11:0] corrected;

  // ***************************************************************
  // trim arithmetic
  // ***************************************************************

  // result in quarter lsb: raw*4 plus gain share plus offset
  always_comb begin
    prod    = $signed({1'b0, st_r.raw}) * $signed(st_r.gain);
    quarter = $signed({11'h000, st_r.raw, 2'h0})
            + 25'(prod >>> 12)
            + 25'($signed(st_r.ofs));
    // clamp so a trim near the ends never wraps the code
    if (quarter < 0) begin
      corrected = 12'h000;
    end else if (quarter[24:2] > 23'(`SAC_CODE_MAX)) begin
      corrected = `SAC_CODE_MAX;
    end else begin
      corrected = quarter[13:2];
    end
  end

  // ***************************************************************
  // next state
  // ***************************************************************

  // bus slave, sequencer and flags in one pass
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    start          = 1'b0;
    done           = 1'b0;
    // one wait state: answer the cycle after penable rises
    acc = psel_in & penable_in & ~st_r.pready;
    if (acc) begin
      st_nxt.pready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      if (paddr_in == `SAC_STATUS_ADDR) begin
        st_nxt.prdata = {31'h0000_0000, st_r.ready};
      end else if (paddr_in == `SAC_RESULT_ADDR) begin
        st_nxt.prdata = {20'h00000, st_r.result};
        if (!pwrite_in) begin
          st_nxt.ready = 1'b0;
        end
      end else if (paddr_in == `SAC_IFRST_ADDR) begin
        // reads as zero; any written value restores the defaults
        if (pwrite_in) begin
          st_nxt = reg_defaults();
          st_nxt.pready = 1'b1;
        end
      end else if (paddr_in == `SAC_GAIN_ADDR) begin
        st_nxt.prdata = {22'h000000, st_r.gain};
        if (pwrite_in) begin
          st_nxt.gain = pwdata_in[9:0];
        end
      end else if (paddr_in == `SAC_OFS_ADDR) begin
        st_nxt.prdata = {22'h000000, st_r.ofs};
        if (pwrite_in) begin
          st_nxt.ofs = pwdata_in[9:0];
        end
      end else if (paddr_in == `SAC_CTRL_ADDR) begin
        st_nxt.prdata = {30'h0000_0000, st_r.single, 1'b0};
        if (pwrite_in) begin
          st_nxt.single = pwdata_in[`SAC_CTRL_SINGLE_BIT];
          start         = pwdata_in[`SAC_CTRL_START_BIT];
        end
      end else if (paddr_in == `SAC_IMASK_ADDR) begin
        st_nxt.prdata = {31'h0000_0000, st_r.imask};
        if (pwrite_in) begin
          st_nxt.imask = pwdata_in[0];
        end
      end else if (paddr_in == `SAC_ISTAT_ADDR) begin
        st_nxt.prdata = {31'h0000_0000, st_r.istat};
        if (!pwrite_in) begin
          st_nxt.istat = 1'b0;
        end
      end else begin
        st_nxt.pslverr = 1'b1;
      end
    end

    // sequencer; a start while busy is ignored
    case (st_r.state)
      SAC_ST_ACQ: begin
        // track: balance closed, both arrays on the inputs
        st_nxt.bal_sw = 1'b1;
        st_nxt.pos_sw = 1'b0;
        st_nxt.neg_sw = 1'b0;
        if (start) begin
          st_nxt.state  = SAC_ST_OPEN;
          st_nxt.bal_sw = 1'b0;
          st_nxt.busy   = 1'b1;
        end
      end
      SAC_ST_OPEN: begin
        // switches move only once balance is already open
        st_nxt.state  = SAC_ST_MOVE;
        st_nxt.pos_sw = 1'b1;
        st_nxt.neg_sw = 1'b1;
      end
      SAC_ST_MOVE: begin
        st_nxt.state   = SAC_ST_CONV;
        st_nxt.bit_idx = `SAC_MSB_IDX;
        st_nxt.trial   = 12'h800;
      end
      SAC_ST_CONV: begin
        // comp high: input above trial, keep the bit
        if (!comp_in) begin
          st_nxt.trial[st_r.bit_idx] = 1'b0;
        end
        if (st_r.bit_idx == 4'h0) begin
          st_nxt.raw   = comp_in ? st_r.trial : (st_r.trial & 12'hFFE);
          st_nxt.state = SAC_ST_CORR;
        end else begin
          st_nxt.bit_idx = st_r.bit_idx - 4'h1;
          st_nxt.trial[st_r.bit_idx - 4'h1] = 1'b1;
        end
      end
      SAC_ST_CORR: begin
        // trimmed code lands with the flag in the same edge
        st_nxt.result = corrected;
        st_nxt.state  = SAC_ST_ACQ;
        st_nxt.bal_sw = 1'b1;
        st_nxt.pos_sw = 1'b0;
        st_nxt.neg_sw = 1'b0;
        st_nxt.busy   = 1'b0;
        done          = 1'b1;
      end
      default: begin
        st_nxt.state = SAC_ST_ACQ;
      end
    endcase

    // event set wins over a same-cycle read clear
    if (done) begin
      st_nxt.ready = 1'b1;
      st_nxt.istat = 1'b1;
    end
    st_nxt.neg_gnd = st_nxt.single;
    st_nxt.irq     = st_nxt.istat & st_nxt.imask;
  end

  // ***************************************************************
  // state register
  // ***************************************************************

  // ce low freezes everything, bus answer included
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r <= reg_defaults();
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata_out                    = st_r.prdata;
  assign pready_out                    = st_r.pready;
  assign pslverr_out                   = st_r.pslverr;
  assign cap_dac_out                   = st_r.trial;
  assign comparator_balance_switch_out = st_r.bal_sw;
  assign positive_input_switch_out     = st_r.pos_sw;
  assign negative_input_switch_out     = st_r.neg_sw;
  assign negative_ground_tie_out       = st_r.neg_gnd;
  assign busy_out                      = st_r.busy;
  assign irq_out                       = st_r.irq;

  // ***************************************************************
  // checks
  // ***************************************************************

  default clocking sac_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // approximation cycles counted here, a long repetition would be costly to unroll
  logic [3:0] conv_cnt_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_cnt_r <= 4'h0;
    end else if (ce_in) begin
      if (st_r.state == SAC_ST_CONV) begin
        conv_cnt_r <= conv_cnt_r + 4'h1;
      end else begin
        conv_cnt_r <= 4'h0;
      end
    end
  end

  a_acq_switches: assert property (
    st_r.state == SAC_ST_ACQ |-> st_r.bal_sw && !st_r.pos_sw && !st_r.neg_sw
  ) else $error("acquisition switch setting wrong");

  a_balance_first: assert property (
    $rose(st_r.pos_sw) |-> !st_r.bal_sw && $past(!st_r.bal_sw) && !$past(st_r.pos_sw)
  ) else $error("input switch moved before balance opened");

  a_inputs_held: assert property (
    st_r.state == SAC_ST_CONV |-> st_r.pos_sw && st_r.neg_sw && !st_r.bal_sw
  ) else $error("inputs not held off during conversion");

  a_conv_length: assert property (
    st_r.state == SAC_ST_CORR |-> conv_cnt_r == `SAC_CONV_STEPS
  ) else $error("approximation did not take twelve steps");

  a_first_trial: assert property (
    st_r.state == SAC_ST_CONV && st_r.bit_idx == `SAC_MSB_IDX |-> st_r.trial == 12'h800
  ) else $error("approximation did not start at mid scale");

  a_irq_level: assert property (
    st_r.irq == (st_r.istat & st_r.imask)
  ) else $error("interrupt level differs from masked status");

  a_ready_on_done: assert property (
    ce_in && st_r.state == SAC_ST_CORR && !rst_in
      |=> st_r.ready && st_r.istat && st_r.result == $past(corrected)
  ) else $error("result or ready missing after conversion");

  a_ready_clear: assert property (
    ce_in && acc && !pwrite_in && paddr_in == `SAC_RESULT_ADDR
      && st_r.state != SAC_ST_CORR |=> !st_r.ready
  ) else $error("ready not cleared by result read");

  a_ifrst_defaults: assert property (
    ce_in && acc && pwrite_in && paddr_in == `SAC_IFRST_ADDR
      |=> st_r.gain == `SAC_GAIN_RST && st_r.ofs == `SAC_OFS_RST && !st_r.ready
  ) else $error("interface reset left a register changed");

  a_gain_write: assert property (
    ce_in && acc && pwrite_in && paddr_in == `SAC_GAIN_ADDR
      |=> st_r.gain == $past(pwdata_in[9:0])
  ) else $error("gain coefficient not stored");

  a_ofs_write: assert property (
    ce_in && acc && pwrite_in && paddr_in == `SAC_OFS_ADDR
      |=> st_r.ofs == $past(pwdata_in[9:0])
  ) else $error("offset coefficient not stored");

  a_single_ground: assert property (
    st_r.neg_gnd == st_r.single
  ) else $error("negative path not grounded in single-ended mode");

  a_zero_trim: assert property (
    st_r.gain == 10'h000 && st_r.ofs == 10'h000 |-> corrected == st_r.raw
  ) else $error("untrimmed result differs from raw code");

endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the converter sequencer, trim and register file
`include "sac_map.svh"
`default_nettype none
module tb_top
  import sac_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [31:0] d;
    logic [31:0] m;
    logic        e;
  } sac_exp_t;

  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [31:0] paddr_in   = 32'h0;
  logic [31:0] pwdata_in  = 32'h0;
  logic [11:0] vin_r      = 12'h000;
  logic        single_exp = 1'b0;
  logic        bal_q      = 1'b1;
  wire  logic  comp_in;
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, busy_out, irq_out;
  logic [11:0] cap_dac_out;
  logic        bal_sw, pos_sw, neg_sw, gnd_tie;
  sac_exp_t    exp_q[$];
  sac_exp_t    ent;
  int          num_errors = 0;
  int          checks     = 0;
  logic [9:0]  g;

  // ideal comparator: an analog input level against the dac trial code
  assign comp_in = (vin_r >= cap_dac_out);

  always #2 clk_in = ~clk_in;

  sac_ctrl dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .comp_in(comp_in),
    .cap_dac_out(cap_dac_out), .comparator_balance_switch_out(bal_sw),
    .positive_input_switch_out(pos_sw), .negative_input_switch_out(neg_sw),
    .negative_ground_tie_out(gnd_tie), .busy_out(busy_out), .irq_out(irq_out)
  );

  // ***************************************************************
  // compare and closing tasks
  // ***************************************************************
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // corrected code, floor shift of the gain term, clamped to the code range
  function automatic logic [11:0] exp_code(input logic [11:0] v, input logic [9:0] gc,
                                           input logic [9:0] oc);
    int r;
    r = (int'(v) * 4 + ((int'(v) * int'($signed(gc))) >>> 12) + int'($signed(oc))) / 4;
    if (r < 0) r = 0;
    if (r > 4095) r = 4095;
    return r[11:0];
  endfunction

  // ***************************************************************
  // apb master: the note is queued before the request goes out
  // ***************************************************************
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic [31:0] em, input logic ee);
    int n;
    exp_q.push_back('{ed, em, ee});
    @(posedge clk_in);
    psel_in   <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in  <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n == 50) begin
      num_errors++;
      wrap_up;
    end
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask

  // one conversion with trims, mask and mode; optional start while busy
  task automatic conv(input logic [11:0] v, input logic [9:0] gc, input logic [9:0] oc,
                      input logic s, input logic m, input logic again);
    int n;
    vin_r <= v;
    single_exp = s;
    wr(`SAC_GAIN_ADDR, {22'h0, gc});
    wr(`SAC_OFS_ADDR, {22'h0, oc});
    wr(`SAC_IMASK_ADDR, {31'h0, m});
    wr(`SAC_CTRL_ADDR, {30'h0, s, 1'b1});
    if (again) wr(`SAC_CTRL_ADDR, {30'h0, s, 1'b1});
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (busy_out !== 1'b0 && n < 40);
    if (n == 40) begin
      num_errors++;
      wrap_up;
    end
    repeat (2) @(posedge clk_in);
    cmp1(busy_out, 1'b0);
    cmp1(irq_out, m);
    rd(`SAC_STATUS_ADDR, 32'h1, 32'h1);
    rd(`SAC_RESULT_ADDR, {20'h0, exp_code(v, gc, oc)}, 32'hFFF);
    rd(`SAC_STATUS_ADDR, 32'h0, 32'h1);
    rd(`SAC_ISTAT_ADDR, 32'h1, 32'h1);
    repeat (2) @(posedge clk_in);
    cmp1(irq_out, 1'b0);
  endtask

  // ***************************************************************
  // monitor: bus answers against notes, switches every cycle
  // ***************************************************************
  always @(posedge clk_in) begin
    if (!rst_in && pready_out === 1'b1 && psel_in && penable_in) begin
      if (exp_q.size() == 0) begin
        ent = '{32'h0, 32'h0, 1'b0};
        num_errors++;
      end else ent = exp_q.pop_front();
      cmp32(prdata_out & ent.m, ent.d & ent.m);
      cmp1(pslverr_out, ent.e);
    end
    if (!rst_in) begin
      if (busy_out !== 1'b1) begin
        cmp1(bal_sw, 1'b1);
        cmp1(pos_sw | neg_sw, 1'b0);
      end else begin
        cmp1(gnd_tie, single_exp);
        if (bal_q) cmp1(pos_sw | neg_sw, 1'b0);
        cmp1(bal_sw & (pos_sw | neg_sw), 1'b0);
      end
    end
    bal_q <= bal_sw;
  end

  // hang guard, far beyond the expected few thousand cycles
  initial begin
    #100000;
    num_errors++;
    wrap_up;
  end

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    void'($urandom(32'hD3B04D22));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`SAC_GAIN_ADDR, {22'h0, `SAC_GAIN_RST}, 32'h3FF);
    rd(`SAC_OFS_ADDR, {22'h0, `SAC_OFS_RST}, 32'h3FF);
    rd(`SAC_IFRST_ADDR, 32'h0, 32'hFFFFFFFF);
    rd(`SAC_STATUS_ADDR, 32'h0, 32'h1);
    // unmapped address is refused, status ignores writes
    apb(1'b0, 32'hFFFF0520, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(`SAC_STATUS_ADDR, 32'hFFFFFFFF);
    rd(`SAC_STATUS_ADDR, 32'h0, 32'h1);
    g = $urandom;
    wr(`SAC_GAIN_ADDR, {22'h0, g});
    rd(`SAC_GAIN_ADDR, {22'h0, g}, 32'h3FF);
    g = $urandom;
    wr(`SAC_OFS_ADDR, {22'h0, g});
    rd(`SAC_OFS_ADDR, {22'h0, g}, 32'h3FF);
    // clamp corners first, then random levels, trims, modes and masks
    conv(12'h000, 10'h000, 10'h200, 1'b0, 1'b1, 1'b0);
    conv(12'hFFF, 10'h1FF, 10'h1FF, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      conv($urandom, $urandom, $urandom, i[0], i[1], i == 3);
    end
    // software offset trim: grounded input, step the coefficient down
    g = 10'h010;
    while (exp_code(12'h000, 10'h000, g) > 12'h001) begin
      conv(12'h000, 10'h000, g, 1'b1, 1'b0, 1'b0);
      g = g - 10'h001;
    end
    conv(12'h000, 10'h000, g, 1'b1, 1'b0, 1'b0);
    // software gain trim: input near reference, step the coefficient up
    g = 10'h000;
    while (exp_code(12'hFF8, g, 10'h000) < 12'hFFE) begin
      conv(12'hFF8, g, 10'h000, 1'b0, 1'b1, 1'b0);
      g = g + 10'h001;
    end
    conv(12'hFF8, g, 10'h000, 1'b0, 1'b1, 1'b0);
    // interface reset brings every register back to its default
    wr(`SAC_IMASK_ADDR, 32'h1);
    wr(`SAC_GAIN_ADDR, 32'h155);
    wr(`SAC_IFRST_ADDR, $urandom);
    rd(`SAC_GAIN_ADDR, {22'h0, `SAC_GAIN_RST}, 32'h3FF);
    rd(`SAC_OFS_ADDR, {22'h0, `SAC_OFS_RST}, 32'h3FF);
    rd(`SAC_IMASK_ADDR, 32'h0, 32'h1);
    rd(`SAC_RESULT_ADDR, 32'h0, 32'hFFF);
    rd(`SAC_IFRST_ADDR, 32'h0, 32'hFFFFFFFF);
    repeat (4) @(posedge clk_in);
    wrap_up;
  end
endmodule
`default_nettype wire
